/* File: rtl/cmc_pkg.sv */
/*
 file: constants for the can mode control and transmit priority block.
 assumes: used by cmc_top and its bench; register map reached over apb, one word each.
*/
package cmc_pkg;
   // ==========================================
   // register byte offsets
   localparam logic [7:0] CMC_OFS_CTRL2 = 8'h00;
   localparam logic [7:0] CMC_OFS_CTRL1 = 8'h04;
   localparam logic [7:0] CMC_OFS_STAT = 8'h08;
   localparam logic [7:0] CMC_OFS_LEN = 8'h0C;
   localparam logic [7:0] CMC_OFS_PRIO0 = 8'h10;
   localparam logic [7:0] CMC_OFS_TXE = 8'h20;
   localparam logic [7:0] CMC_OFS_IRQS = 8'h24;
   localparam logic [7:0] CMC_OFS_IRQM = 8'h28;
   localparam logic [7:0] CMC_OFS_SEL = 8'h2C;
   // ==========================================
   // second control register fields
   localparam int CMC_BIT_ENABLE = 7;
   localparam int CMC_BIT_CLOCK_SOURCE_SELECT = 6;
   localparam int CMC_BIT_LOOP = 5;
   localparam int CMC_BIT_MONITOR = 4;
   localparam int CMC_BIT_WFILT = 2;
   // first control register fields
   localparam int CMC_BIT_INIT_REQUEST = 0;
   localparam int CMC_BIT_WAKE_EN = 2;
   // status register fields
   localparam int CMC_BIT_INIT_ACKNOWLEDGE = 0;
   // interrupt status bits
   localparam int CMC_IRQ_TX = 0;
   localparam int CMC_IRQ_RX = 1;
   localparam int CMC_IRQ_WAKE = 2;
   localparam int CMC_IRQ_W = 3;
   // ==========================================
   // reset values and lengths
   localparam logic [7:0] CMC_CTRL2_RST = 8'h01;
   localparam logic [7:0] CMC_CTRL1_RST = 8'h01;
   localparam logic [3:0] CMC_LEN_MAX = 4'h8;
   // ==========================================
   // wake filter: least dominant pulse, in ns, and its cycle count at 100 MHz
   localparam int CMC_CLK_NS = 10;
   localparam int CMC_WAKE_PULSE_NS = 2000;
   localparam int CMC_WAKE_CYC = (CMC_WAKE_PULSE_NS + CMC_CLK_NS - 1) / CMC_CLK_NS;
   typedef enum logic [2:0] {
      CMC_ST_IDLE = 3'b001,
      CMC_ST_SEND = 3'b010,
      CMC_ST_DONE = 3'b100
   } cmc_state_t;
endpackage

/* File: rtl/cmc_top.sv */
/*
 file: mode control, length code and local transmit priority of a can controller.
 assumes: apb master on the register side; bit-level framing lives outside and is
 driven through the frame strobe ports; special_mode is a static system strap.
*/
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
// How it works
// [RULE1] enable bit seven switches the controller on
// [RULE2] control writes only while init requested and acknowledged
// [RULE3] enable write once, unless special mode
// [RULE4] bit six picks oscillator or bus clock
// [RULE5] loopback feeds transmit stream into receiver
// [RULE6] loopback ignores rx pin, tx recessive
// [RULE7] loopback ignores ack slot, raises both interrupts
// [RULE8] monitor mode receives, never acks or errors; code only gates error frames, bus_tx_pin is not held recessive
// [RULE9] monitor freezes error counters, blocks transmit
// [RULE10] wake filter: any dominant or long pulse
// [RULE11] length code low nibble, zero to eight bytes
// [RULE12] remote frame sends code, zero data bytes
// [RULE13] non-empty buffers arbitrate just before start
// [RULE14] smallest local priority value wins
// [RULE15] equal priority goes to lowest buffer
// [RULE16] codes above eight send eight bytes
module cmc_top
#(
   parameter int NUM_BUF = 3,
   parameter int WAKE_CYC = cmc_pkg::CMC_WAKE_CYC
)
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic special_mode,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_clk_tick,
   input wire logic bus_clk_tick,
   input wire logic sof_request,
   input wire logic remote_frame,
   input wire logic ctrl_tx_bit,
   input wire logic ctrl_tx_oe,
   input wire logic ack_slot,
   input wire logic frame_tx_done,
   input wire logic frame_rx_done,
   input wire logic err_inc_tx,
   input wire logic err_inc_rx,
   input wire logic bus_rx_pin,
   output logic bus_tx_pin,
   output logic ctrl_rx_bit,
   output logic ack_ignore,
   output logic error_frame_allow,
   output logic controller_enable,
   output logic clock_source_select,
   output logic can_clk_tick,
   output logic tx_start,
   output logic [1:0] tx_buf_sel,
   output logic [3:0] tx_length_code,
   output logic [3:0] tx_byte_count,
   output logic [7:0] tx_err_count,
   output logic [7:0] rx_err_count,
   output logic wake_event,
   output logic irq
);
   import cmc_pkg::*;

   // ==========================================
   // state
   typedef struct packed {
      logic [7:0] ctrl2;
      logic [7:0] ctrl1;
      logic init_acknowledge;
      logic en_written;
      logic [3:0] len;
      logic [NUM_BUF-1:0][7:0] prio;
      logic [NUM_BUF-1:0] txe;
      logic [CMC_IRQ_W-1:0] irqs;
      logic [CMC_IRQ_W-1:0] irqm;
      logic [1:0] sel;
      logic [3:0] cnt;
      logic start;
      logic [7:0] tec;
      logic [7:0] rec;
      logic [15:0] wcnt;
      logic wake;
      logic [31:0] rdata;
      cmc_state_t st;
   } cmc_state_s_t;

   cmc_state_s_t s_r;
   cmc_state_s_t s_nxt;

   logic acc;
   logic wr;
   logic in_init;
   logic loop_on;
   logic mon_on;
   logic [1:0] win_idx;
   logic win_any;
   logic [7:0] win_prio;
   logic [CMC_IRQ_W-1:0] ev;

   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign in_init = s_r.ctrl1[CMC_BIT_INIT_REQUEST] && s_r.init_acknowledge;
   assign loop_on = s_r.ctrl2[CMC_BIT_LOOP];
   assign mon_on = s_r.ctrl2[CMC_BIT_MONITOR];

   // ==========================================
   // local priority arbitration
   always_comb
   begin
      win_any = 1'b0;
      win_idx = 2'd0;
      win_prio = 8'hFF;
      for (int i = 0; i < NUM_BUF; i++)
      begin
         // strict less-than keeps the lowest index on a tie [RULE15]
         if (!s_r.txe[i] && (!win_any || s_r.prio[i] < win_prio)) // [RULE13] [RULE14]
         begin
            win_any = 1'b1;
            win_idx = 2'(i);
            win_prio = s_r.prio[i];
         end
      end
   end

   // ==========================================
   // next state
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.start = 1'b0;
      s_nxt.wake = 1'b0;
      // acknowledge follows the request one cycle later
      s_nxt.init_acknowledge = s_r.ctrl1[CMC_BIT_INIT_REQUEST];
      if (wr && paddr == CMC_OFS_CTRL1)
      begin
         s_nxt.ctrl1 = pwdata[7:0];
      end
      if (wr && paddr == CMC_OFS_CTRL2 && in_init) // [RULE2]
      begin
         s_nxt.ctrl2[6:0] = pwdata[6:0];
         // enable is sticky after its first write outside special mode [RULE3]
         if (special_mode || !s_r.en_written)
         begin
            s_nxt.ctrl2[CMC_BIT_ENABLE] = pwdata[CMC_BIT_ENABLE];
            s_nxt.en_written = 1'b1;
         end
      end
      if (wr && paddr == CMC_OFS_LEN)
      begin
         s_nxt.len = pwdata[3:0]; // [RULE11]
      end
      for (int i = 0; i < NUM_BUF; i++)
      begin
         if (wr && paddr == CMC_OFS_PRIO0 + 8'(4 * i))
         begin
            s_nxt.prio[i] = pwdata[7:0];
         end
         if (wr && paddr == CMC_OFS_TXE)
         begin
            s_nxt.txe[i] = pwdata[i];
         end
      end
      if (wr && paddr == CMC_OFS_IRQM)
      begin
         s_nxt.irqm = pwdata[CMC_IRQ_W-1:0];
      end

      // transmit sequencing
      case (s_r.st)
         CMC_ST_IDLE:
         begin
            // monitor mode never transmits [RULE9]
            if (controller_enable && !mon_on && sof_request && win_any) // [RULE1] [RULE13]
            begin
               s_nxt.sel = win_idx;
               s_nxt.start = 1'b1;
               // remote frames carry no data [RULE12], long codes clip to eight [RULE16]
               s_nxt.cnt = remote_frame ? 4'h0 : (s_r.len > CMC_LEN_MAX ? CMC_LEN_MAX : s_r.len);
               s_nxt.st = CMC_ST_SEND;
            end
         end
         CMC_ST_SEND:
         begin
            if (frame_tx_done)
            begin
               s_nxt.txe[s_r.sel] = 1'b1;
               s_nxt.st = CMC_ST_DONE;
            end
         end
         CMC_ST_DONE:
         begin
            s_nxt.st = CMC_ST_IDLE;
         end
         default:
         begin
            s_nxt.st = CMC_ST_IDLE;
         end
      endcase

      // error counters frozen in monitor mode [RULE9]
      if (controller_enable && !mon_on)
      begin
         if (err_inc_tx && s_r.tec != 8'hFF)
            s_nxt.tec = s_r.tec + 8'd1;
         if (err_inc_rx && s_r.rec != 8'hFF)
            s_nxt.rec = s_r.rec + 8'd1;
      end

      // wake detection on a dominant (low) bus level [RULE10]
      if (s_r.ctrl1[CMC_BIT_WAKE_EN] && !bus_rx_pin)
      begin
         if (s_r.wcnt != 16'hFFFF)
            s_nxt.wcnt = s_r.wcnt + 16'd1;
         if (!s_r.ctrl2[CMC_BIT_WFILT] || 32'(s_r.wcnt) + 32'd1 == WAKE_CYC)
            s_nxt.wake = (s_r.wcnt == 16'd0) || s_r.ctrl2[CMC_BIT_WFILT];
      end
      else
      begin
         s_nxt.wcnt = 16'd0;
      end

      // sticky interrupts: a set in the clearing cycle wins
      if (wr && paddr == CMC_OFS_IRQS)
         s_nxt.irqs = s_r.irqs & ~pwdata[CMC_IRQ_W-1:0];
      s_nxt.irqs = s_nxt.irqs | ev;

      // read data captured in the setup phase, shown in the access phase
      if (psel && !penable)
      begin
         s_nxt.rdata = 32'h0000_0000;
         case (paddr)
            CMC_OFS_CTRL2: s_nxt.rdata[7:0] = s_r.ctrl2;
            CMC_OFS_CTRL1: s_nxt.rdata[7:0] = s_r.ctrl1;
            CMC_OFS_STAT: s_nxt.rdata[CMC_BIT_INIT_ACKNOWLEDGE] = s_r.init_acknowledge;
            CMC_OFS_LEN: s_nxt.rdata[3:0] = s_r.len;
            CMC_OFS_TXE: s_nxt.rdata[NUM_BUF-1:0] = s_r.txe;
            CMC_OFS_IRQS: s_nxt.rdata[CMC_IRQ_W-1:0] = s_r.irqs;
            CMC_OFS_IRQM: s_nxt.rdata[CMC_IRQ_W-1:0] = s_r.irqm;
            CMC_OFS_SEL: s_nxt.rdata[15:0] = {s_r.rec, s_r.tec};
            default:
            begin
               for (int i = 0; i < NUM_BUF; i++)
                  if (paddr == CMC_OFS_PRIO0 + 8'(4 * i))
                     s_nxt.rdata[7:0] = s_r.prio[i];
            end
         endcase
      end
   end

   // both events raised in loopback just as on the real bus [RULE7]
   assign ev = {s_r.wake, frame_rx_done, frame_tx_done && s_r.st == CMC_ST_SEND};

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         s_r <= '0;
         s_r.ctrl2 <= CMC_CTRL2_RST;
         s_r.ctrl1 <= CMC_CTRL1_RST;
         s_r.txe <= '1;
         s_r.st <= CMC_ST_IDLE;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ==========================================
   // outputs
   assign controller_enable = s_r.ctrl2[CMC_BIT_ENABLE]; // [RULE1]
   assign clock_source_select = s_r.ctrl2[CMC_BIT_CLOCK_SOURCE_SELECT];
   assign can_clk_tick = clock_source_select ? bus_clk_tick : osc_clk_tick; // [RULE4]
   // loopback: own stream to receiver, pin ignored, line held recessive [RULE5] [RULE6]
   assign ctrl_rx_bit = loop_on ? ctrl_tx_bit : bus_rx_pin;
   assign bus_tx_pin = (!controller_enable || loop_on || !ctrl_tx_oe) ? 1'b1 : ctrl_tx_bit;
   // acknowledge slot level does not matter to our own frame in loopback [RULE7]
   assign ack_ignore = loop_on && ack_slot;
   // monitor mode: no error frames; bus_tx_pin still follows ctrl_tx_bit while ctrl_tx_oe [RULE8]
   assign error_frame_allow = controller_enable && !mon_on;
   assign tx_start = s_r.start;
   assign tx_buf_sel = s_r.sel;
   assign tx_length_code = s_r.len; // [RULE12]
   assign tx_byte_count = s_r.cnt;
   assign tx_err_count = s_r.tec;
   assign rx_err_count = s_r.rec;
   assign wake_event = s_r.wake;
   assign irq = |(s_r.irqs & s_r.irqm);
   assign prdata = s_r.rdata;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
endmodule

/* File: testbench/cmc_bus_node.sv */
/*
 remote can node on the bus wire, wired-and with a pull-up to recessive.
 assumes: the bench asks for dominant pulses through hold_dominant.
*/
`timescale 1ns/1ps
module cmc_bus_node
(
   input wire logic clock,
   input wire logic bus_tx_pin,
   output logic bus_rx_pin
);
   logic drive_low = 1'b0;
   // the pull-up makes an undriven wire read recessive, never a stale level
   assign bus_rx_pin = bus_tx_pin & ~drive_low;
   task automatic hold_dominant(input int n);
      @(posedge clock);
      drive_low <= 1'b1;
      repeat (n) @(posedge clock);
      drive_low <= 1'b0;
   endtask
endmodule

/* File: testbench/cmc_top_checker.sv */
/*
 port relation checks for cmc_top.
 assumes: one clock domain, resetn asynchronous and active low.
*/
`timescale 1ns/1ps
module cmc_top_checker
#(
   parameter int NUM_BUF = 3
)
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic osc_clk_tick,
   input wire logic bus_clk_tick,
   input wire logic can_clk_tick,
   input wire logic clock_source_select,
   input wire logic controller_enable,
   input wire logic error_frame_allow,
   input wire logic sof_request,
   input wire logic remote_frame,
   input wire logic ctrl_tx_bit,
   input wire logic ctrl_rx_bit,
   input wire logic bus_tx_pin,
   input wire logic ack_ignore,
   input wire logic tx_start,
   input wire logic [1:0] tx_buf_sel,
   input wire logic [3:0] tx_length_code,
   input wire logic [3:0] tx_byte_count,
   input wire logic [7:0] tx_err_count,
   input wire logic [7:0] rx_err_count,
   input wire logic wake_event
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   // ==========
   chk_clk_pick: assert property (
      can_clk_tick == (clock_source_select ? bus_clk_tick : osc_clk_tick)) else $error("wrong clock source");
   chk_off_quiet: assert property (
      !controller_enable |-> bus_tx_pin && !error_frame_allow) else $error("disabled block active");
   chk_loop_path: assert property (
      ack_ignore |-> bus_tx_pin && ctrl_rx_bit == ctrl_tx_bit) else $error("loopback path wrong");
   chk_start_cause: assert property (
      tx_start |-> $past(sof_request) && $past(error_frame_allow)) else $error("start without cause");
   chk_data_count: assert property (
      tx_start && !$past(remote_frame) |-> tx_byte_count == (tx_length_code > 4'h8 ? 4'h8 : tx_length_code))
      else $error("data byte count wrong");
   chk_remote_zero: assert property (
      tx_start && $past(remote_frame) |-> tx_byte_count == 4'h0) else $error("remote frame carries data");
   chk_err_frozen: assert property (
      controller_enable && !error_frame_allow |=> $stable(tx_err_count) && $stable(rx_err_count))
      else $error("error counters moved");
   chk_sel_range: assert property (
      tx_start |-> int'(tx_buf_sel) < NUM_BUF) else $error("buffer select out of range");
   chk_wake_pulse: assert property (
      wake_event |=> !wake_event) else $error("wake event too long");
   cov_start: cover property (tx_start);
   cov_loop_ack: cover property (ack_ignore);
   cov_wake: cover property (wake_event);
endmodule
bind cmc_top cmc_top_checker #(.NUM_BUF(NUM_BUF)) i_chk (.*);

/* File: testbench/can_mode_control_tx_priority_tb.sv */
/*
 self-checking bench for cmc_top: apb master, random framer levels, remote node.
 assumes: zero wait apb slave, offsets from cmc_pkg, short wake filter.
*/
`timescale 1ns/1ps
module can_mode_control_tx_priority_tb;
   import cmc_pkg::*;
   logic clock = 0, resetn = 0, special_mode = 0, psel = 0, penable = 0, pwrite = 0, quiet = 0;
   logic osc_clk_tick = 0, bus_clk_tick = 0, sof_request = 0, remote_frame = 0, ctrl_tx_bit = 0;
   logic ctrl_tx_oe = 0, ack_slot = 0, frame_tx_done = 0, frame_rx_done = 0, err_inc_tx = 0, err_inc_rx = 0;
   logic pready, pslverr, bus_rx_pin, bus_tx_pin, ctrl_rx_bit, ack_ignore, error_frame_allow, controller_enable;
   logic clock_source_select, can_clk_tick, tx_start, wake_event, irq;
   logic [1:0] tx_buf_sel;
   logic [3:0] tx_length_code, tx_byte_count, ln;
   logic [7:0] paddr = 0, tx_err_count, rx_err_count, pr [3];
   logic [31:0] pwdata = 0, prdata, q, rs = 32'h0000_3e94, lf = 32'h0000_3e94;
   int failures = 0, n_compared = 0, cyc = 0, wakes = 0, w0;
   cmc_top #(.NUM_BUF(3), .WAKE_CYC(4)) i_dut
   (
      .clock(clock),
      .resetn(resetn),
      .special_mode(special_mode),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .osc_clk_tick(osc_clk_tick),
      .bus_clk_tick(bus_clk_tick),
      .sof_request(sof_request),
      .remote_frame(remote_frame),
      .ctrl_tx_bit(ctrl_tx_bit),
      .ctrl_tx_oe(ctrl_tx_oe),
      .ack_slot(ack_slot),
      .frame_tx_done(frame_tx_done),
      .frame_rx_done(frame_rx_done),
      .err_inc_tx(err_inc_tx),
      .err_inc_rx(err_inc_rx),
      .bus_rx_pin(bus_rx_pin),
      .bus_tx_pin(bus_tx_pin),
      .ctrl_rx_bit(ctrl_rx_bit),
      .ack_ignore(ack_ignore),
      .error_frame_allow(error_frame_allow),
      .controller_enable(controller_enable),
      .clock_source_select(clock_source_select),
      .can_clk_tick(can_clk_tick),
      .tx_start(tx_start),
      .tx_buf_sel(tx_buf_sel),
      .tx_length_code(tx_length_code),
      .tx_byte_count(tx_byte_count),
      .tx_err_count(tx_err_count),
      .rx_err_count(rx_err_count),
      .wake_event(wake_event),
      .irq(irq)
   );
   cmc_bus_node i_node (.clock(clock), .bus_tx_pin(bus_tx_pin), .bus_rx_pin(bus_rx_pin));
   initial
   begin
      forever #5 clock = ~clock;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [1:0] exp_sel();
      logic [1:0] b = 0;
      for (int i = 1; i < 3; i++)
         if (pr[i] < pr[b]) b = 2'(i);
      return b;
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      do @(posedge clock);
      while (pready !== 1'b1);
      q = prdata;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic strobe(input logic sof, input logic err, input logic done);
      @(posedge clock);
      {sof_request, err_inc_tx, err_inc_rx, frame_tx_done, frame_rx_done} <= {sof, err, err, done, done};
      @(posedge clock);
      {sof_request, err_inc_tx, err_inc_rx, frame_tx_done, frame_rx_done} <= 5'h0;
   endtask
   // ==========
   // random framer levels every cycle; quiet keeps the wire recessive
   always @(posedge clock)
   begin
      lf <= lfsr(lf);
      {osc_clk_tick, bus_clk_tick, ctrl_tx_bit, ack_slot} <= lf[3:0];
      ctrl_tx_oe <= lf[4] & ~quiet;
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         failures++;
         results();
      end
   end
   always @(negedge clock)
      if (wake_event === 1'b1) wakes <= wakes + 1;
   initial
   begin
      repeat (6) @(posedge clock);
      resetn <= 1;
      apb(0, CMC_OFS_CTRL2, 0);
      check("ctrl2 reset", 32'h0000_0001, q);
      apb(0, CMC_OFS_TXE, 0);
      check("txe reset", 32'h0000_0007, q);
      apb(0, 8'h3C, 0);
      check("unmapped", 0, q);
      apb(1, CMC_OFS_CTRL1, 0);
      apb(1, CMC_OFS_CTRL2, 32'h0000_00A0);
      apb(0, CMC_OFS_CTRL2, 0);
      check("ctrl2 locked", 0, q & 32'h0000_00F4);
      apb(1, CMC_OFS_CTRL1, 1);
      apb(1, CMC_OFS_CTRL2, 32'h0000_0080);
      apb(1, CMC_OFS_CTRL2, 32'h0000_0040);
      apb(0, CMC_OFS_CTRL2, 0);
      check("enable once", 32'h0000_00C0, q & 32'h0000_00F4);
      check("enable pin", 1, 32'(controller_enable));
      check("clock source pin", 1, 32'(clock_source_select));
      special_mode <= 1;
      apb(1, CMC_OFS_CTRL2, 32'h0000_0040);
      apb(0, CMC_OFS_CTRL2, 0);
      check("enable special", 32'h0000_0040, q & 32'h0000_00F4);
      apb(1, CMC_OFS_CTRL2, 32'h0000_00E0);
      $display("test mode register done");
      fork
         i_node.hold_dominant(6);
      join_none
      repeat (5)
      begin
         @(negedge clock);
         check("loop rx", 32'(ctrl_tx_bit), 32'(ctrl_rx_bit));
         check("loop tx", 1, 32'(bus_tx_pin));
      end
      apb(1, CMC_OFS_IRQM, 0);
      // a real frame in loopback: the transmit event only counts while sending
      apb(1, CMC_OFS_TXE, 32'h0000_0006);
      strobe(1, 0, 0);
      strobe(0, 0, 1);
      @(negedge clock);
      check("irq masked", 0, 32'(irq));
      apb(1, CMC_OFS_IRQM, 7);
      apb(0, CMC_OFS_IRQS, 0);
      check("both irqs", 3, q);
      check("irq up", 1, 32'(irq));
      apb(1, CMC_OFS_IRQS, 3);
      @(negedge clock);
      check("irq cleared", 0, 32'(irq));
      apb(1, CMC_OFS_CTRL2, 32'h0000_00C0);
      $display("test loopback done");
      for (int k = 0; k < 14; k++)
      begin
         rs = lfsr(rs);
         for (int i = 0; i < 3; i++)
         begin
            pr[i] = (k < 2) ? 8'h05 : rs[8*i +: 8];
            apb(1, CMC_OFS_PRIO0 + 8'(4 * i), 32'(pr[i]));
         end
         ln = 4'(k + 4);
         apb(1, CMC_OFS_LEN, 32'(ln));
         apb(1, CMC_OFS_TXE, 0);
         @(posedge clock);
         remote_frame <= rs[31];
         strobe(1, 0, 0);
         do @(negedge clock);
         while (tx_start !== 1'b1);
         check("buffer", 32'(exp_sel()), 32'(tx_buf_sel));
         check("bytes", rs[31] ? 0 : (ln > 8 ? 8 : 32'(ln)), 32'(tx_byte_count));
         check("length code", 32'(ln), 32'(tx_length_code));
         strobe(0, 0, 1);
      end
      $display("test priority done");
      strobe(0, 1, 0);
      apb(1, CMC_OFS_CTRL2, 32'h0000_00D0);
      strobe(1, 1, 0);
      repeat (4)
      begin
         @(negedge clock);
         check("monitor start", 0, 32'(tx_start));
      end
      check("tx errors", 1, 32'(tx_err_count));
      check("rx errors", 1, 32'(rx_err_count));
      check("no error frames", 0, 32'(error_frame_allow));
      $display("test monitor done");
      quiet <= 1;
      apb(1, CMC_OFS_CTRL2, 32'h0000_00C4);
      apb(1, CMC_OFS_CTRL1, 5);
      w0 = wakes;
      i_node.hold_dominant(2);
      repeat (6) @(posedge clock);
      check("short pulse", 32'(w0), 32'(wakes));
      i_node.hold_dominant(8);
      repeat (6) @(posedge clock);
      check("long pulse", 32'(w0 + 1), 32'(wakes));
      apb(1, CMC_OFS_CTRL2, 32'h0000_00C0);
      i_node.hold_dominant(1);
      repeat (6) @(posedge clock);
      check("any dominant", 32'(w0 + 2), 32'(wakes));
      $display("test wake done");
      // second reset in mid-run: counters and enable must come back to reset values
      @(posedge clock);
      resetn <= 0;
      repeat (2) @(posedge clock);
      resetn <= 1;
      apb(0, CMC_OFS_SEL, 0);
      check("counters reset", 0, q);
      apb(0, CMC_OFS_CTRL2, 0);
      check("ctrl2 after reset", 32'h0000_0001, q);
      check("enable after reset", 0, 32'(controller_enable));
      check("slave error", 0, 32'(pslverr));
      $display("test reset done");
      results();
   end
endmodule
